// ---- uas_pkg.sv ----
// Shared constants of the serial port.
// Assumes one clock domain.
// What this block does
// - Received bytes wait in a holding buffer
// - Flag overrun when unread byte is overtaken
// - One data location: read receives, write transmits
// - Done flags cleared only by software strobes
// - Four modes: synchronous, 8-bit, two 9-bit
// - Mode 0 master: data on in-pin, clock out
// - Mode 0 write sends eight bits LSB first
// - Mode 0 receive needs enable, clear done flag
// - Mode 0 clock is system clock over twelve
// - Mode 1 frame: start, eight data, stop
// - Mode 1 transmit done at stop-bit start
// - Mode 1 accept needs clear flag, stop check only with multiprocessor bit set
// - Acceptance into free buffer slot stores byte, stop bit, sets done
// - Interrupt request when either done flag set
// - Separate transmit and receive timer selection
// - Timer rollover from all ones gives tick
// - Timer one divides by 32 or 16
// - Timer one period is 256 minus reload
// - Wide timers: 65536 minus reload, over 16
// - Write during transmit sets collision flag
// - Low stop bit sets frame error flag
package uas_pkg;
    localparam logic [1:0] UAS_MODE_SYNC     = 2'h0;
    localparam logic [1:0] UAS_MODE_ASYNC8   = 2'h1;
    localparam logic [1:0] UAS_MODE_ASYNC9_F = 2'h2;
    localparam logic [1:0] UAS_MODE_ASYNC9_V = 2'h3;

    localparam logic [1:0] UAS_SRC_TIMER_ONE = 2'h0;

    localparam int         UAS_DATA_BITS     = 8;
    localparam logic [2:0] UAS_LAST_BIT      = 3'h7;
    localparam logic [3:0] UAS_OS_LAST       = 4'hF;
    localparam logic [3:0] UAS_OS_MID        = 4'h7;

    localparam logic [3:0] UAS_SYNC_DIV_LAST = 4'hB;
    localparam logic [3:0] UAS_SYNC_HALF     = 4'h6;

    localparam logic [1:0] UAS_FIX_DIV_SLOW  = 2'h3;
    localparam logic [1:0] UAS_FIX_DIV_FAST  = 2'h1;

    localparam int         UAS_NUM_TIMERS    = 4;
    localparam logic [15:0] UAS_NARROW_MAX   = 16'h00FF;
    localparam logic [15:0] UAS_WIDE_MAX     = 16'hFFFF;

    typedef enum logic [2:0] {
        UAS_TX_IDLE, UAS_TX_START, UAS_TX_DATA, UAS_TX_NINTH, UAS_TX_STOP, UAS_TX_SYNC
    } uas_tx_state_e;

    typedef enum logic [2:0] {
        UAS_RX_IDLE, UAS_RX_START, UAS_RX_DATA, UAS_RX_NINTH, UAS_RX_STOP,
        UAS_RX_SYNC, UAS_RX_SYNC_DONE
    } uas_rx_state_e;
endpackage

// ---- uas_stream_if.sv ----
// Byte carrier, shifter to holding buffer.
// Assumes one clock.
`timescale 1ns/10ps
`default_nettype none
interface uas_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- uas_hold_buf.sv ----
// Two-entry receive holding buffer.
// Assumes the writer honours ready.
`timescale 1ns/10ps
`default_nettype none
module uas_hold_buf #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    uas_stream_if.snk         in_if,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    if (W < 1) begin : g_bad_width
        $error("width below one");
    end

    logic [W-1:0] mem_r [2];
    logic         wr_ptr_r;
    logic         rd_ptr_r;
    logic [1:0]   count_r;
    logic         push;
    logic         pop;

    assign in_if.ready = (count_r != 2'h2);
    assign push        = in_if.valid && in_if.ready;
    assign pop         = out_valid_o && out_ready_i;
    assign out_valid_o = (count_r != 2'h0);
    assign out_data_o  = mem_r[rd_ptr_r];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_if.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push && !pop) begin
                count_r <= count_r + 2'h1;
            end else if (pop && !push) begin
                count_r <= count_r - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- uas_serial_port.sv ----
// Serial port core: shift and async modes, baud timers, flags.
// Assumes control strobes are one-cycle pulses on clk_i.
`timescale 1ns/10ps
`default_nettype none
module uas_serial_port
    import uas_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic        rx_enable_bit_i,
    input  wire logic        multiproc_enable_bit_i,
    input  wire logic        double_speed_bit_i,
    input  wire logic        tx_clock_sel_hi_i,
    input  wire logic        tx_clock_sel_lo_i,
    input  wire logic        rx_clock_sel_hi_i,
    input  wire logic        rx_clock_sel_lo_i,
    input  wire logic        int_enable_i,
    input  wire logic        tx_ninth_bit_i,
    input  wire logic        timer_one_input_clock_i,
    input  wire logic [7:0]  timer_one_reload_i,
    input  wire logic [2:0]  wide_timer_input_clock_i,
    input  wire logic [47:0] wide_timer_reload_i,
    input  wire logic        data_wr_i,
    input  wire logic [7:0]  data_wr_data_i,
    input  wire logic        data_rd_i,
    output logic [7:0]       serial_data_buffer_o,
    output logic             rx_data_valid_o,
    input  wire logic        tx_done_clr_i,
    input  wire logic        rx_done_clr_i,
    input  wire logic        tx_collision_clr_i,
    input  wire logic        rx_overrun_clr_i,
    input  wire logic        frame_error_clr_i,
    output logic             tx_done_flag_o,
    output logic             rx_done_flag_o,
    output logic             rx_ninth_bit_o,
    output logic             tx_collision_flag_o,
    output logic             rx_overrun_flag_o,
    output logic             frame_error_flag_o,
    output logic             tx_busy_o,
    output logic             irq_o,
    input  wire logic        serial_in_i,
    output logic             serial_in_o,
    output logic             serial_in_oe_o,
    output logic             serial_out_o
);
    // Baud timers
    logic [3:0]  tmr_clk_en;
    logic [15:0] tmr_reload [UAS_NUM_TIMERS];
    logic [15:0] tmr_cnt_r  [UAS_NUM_TIMERS];
    logic [3:0]  ovf_r;

    assign tmr_clk_en = {wide_timer_input_clock_i, timer_one_input_clock_i};

    genvar gi;
    generate
        for (gi = 0; gi < UAS_NUM_TIMERS; gi++) begin : g_tmr
            localparam logic [15:0] TOP = (gi == 0) ? UAS_NARROW_MAX : UAS_WIDE_MAX;
            if (gi == 0) begin : g_narrow
                assign tmr_reload[gi] = {8'h00, timer_one_reload_i};
            end else begin : g_wide
                assign tmr_reload[gi] = wide_timer_reload_i[16*gi-1 -: 16];
            end
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    tmr_cnt_r[gi] <= tmr_reload[gi]; // Full first period
                    ovf_r[gi]     <= 1'b0;
                end else begin
                    ovf_r[gi] <= 1'b0;
                    if (tmr_clk_en[gi]) begin
                        if (tmr_cnt_r[gi] == TOP) begin
                            tmr_cnt_r[gi] <= tmr_reload[gi];
                            ovf_r[gi]     <= 1'b1;
                        end else begin
                            tmr_cnt_r[gi] <= tmr_cnt_r[gi] + 16'h0001;
                        end
                    end
                end
            end
        end
    endgenerate

    // Double speed, reset low
    logic dbl_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dbl_r <= 1'b0;
        end else begin
            dbl_r <= double_speed_bit_i;
        end
    end

    // Fixed-rate tick
    logic [1:0] fix_cnt_r;
    logic       fix_tick;
    assign fix_tick = (fix_cnt_r == 2'h0);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fix_cnt_r <= 2'h0;
        end else if (fix_tick) begin
            fix_cnt_r <= dbl_r ? UAS_FIX_DIV_FAST : UAS_FIX_DIV_SLOW;
        end else begin
            fix_cnt_r <= fix_cnt_r - 2'h1;
        end
    end

    // Ticks: 0 transmit, 1 receive
    logic [1:0] src_sel [2];
    logic [1:0] half_r;
    logic [1:0] os_tick;
    assign src_sel[0] = {tx_clock_sel_hi_i, tx_clock_sel_lo_i};
    assign src_sel[1] = {rx_clock_sel_hi_i, rx_clock_sel_lo_i};

    generate
        for (gi = 0; gi < 2; gi++) begin : g_baud
            logic sel_ovf;
            logic halve;
            assign sel_ovf = ovf_r[src_sel[gi]];
            assign halve   = (src_sel[gi] == UAS_SRC_TIMER_ONE) && !dbl_r;
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    half_r[gi] <= 1'b0;
                end else if (sel_ovf) begin
                    half_r[gi] <= ~half_r[gi];
                end
            end
            always_comb begin
                if (mode_i == UAS_MODE_ASYNC9_F) begin
                    os_tick[gi] = fix_tick;
                end else if (halve) begin
                    os_tick[gi] = sel_ovf && half_r[gi];
                end else begin
                    os_tick[gi] = sel_ovf;
                end
            end
        end
    endgenerate

    // Pin synchroniser
    logic in_meta_r;
    logic in_sync_r;
    logic in_prev_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            in_meta_r <= 1'b1;
            in_sync_r <= 1'b1;
            in_prev_r <= 1'b1;
        end else begin
            in_meta_r <= serial_in_i;
            in_sync_r <= in_meta_r;
            in_prev_r <= in_sync_r;
        end
    end

    uas_tx_state_e tx_st_r;
    uas_rx_state_e rx_st_r;
    logic          nine_bit;
    assign nine_bit = mode_i[1];

    // Mode 0 shift clock divider
    logic [3:0] sdiv_r;
    logic       sync_act;
    logic       sync_fall;
    logic       sync_rise;
    logic       sync_end;
    assign sync_act  = (tx_st_r == UAS_TX_SYNC) || (rx_st_r == UAS_RX_SYNC);
    assign sync_fall = sync_act && (sdiv_r == 4'h0);
    assign sync_rise = sync_act && (sdiv_r == UAS_SYNC_HALF);
    assign sync_end  = sync_act && (sdiv_r == UAS_SYNC_DIV_LAST);
    always_ff @(posedge clk_i) begin
        if (srst_i || !sync_act || sync_end) begin
            sdiv_r <= 4'h0;
        end else begin
            sdiv_r <= sdiv_r + 4'h1;
        end
    end

    // Transmitter
    logic [7:0] tx_sh_r;
    logic [2:0] tx_bit_r;
    logic [3:0] tx_os_r;
    logic       tx_line_r;
    logic       tx_go;
    logic       tx_bit_end;
    logic       tx_done_set;
    logic       wr_busy;
    assign wr_busy    = (tx_st_r != UAS_TX_IDLE) ||
                        ((mode_i == UAS_MODE_SYNC) && (rx_st_r != UAS_RX_IDLE));
    assign tx_go      = data_wr_i && !wr_busy;
    assign tx_bit_end = os_tick[0] && (tx_os_r == UAS_OS_LAST);
    assign tx_busy_o  = (tx_st_r != UAS_TX_IDLE);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_st_r   <= UAS_TX_IDLE;
            tx_sh_r   <= 8'h00;
            tx_bit_r  <= 3'h0;
            tx_os_r   <= 4'h0;
            tx_line_r <= 1'b1;
        end else begin
            if (tx_st_r != UAS_TX_IDLE && tx_st_r != UAS_TX_SYNC && os_tick[0]) begin
                tx_os_r <= tx_os_r + 4'h1;
            end
            case (tx_st_r)
                UAS_TX_IDLE: begin
                    tx_line_r <= 1'b1;
                    tx_os_r   <= 4'h0;
                    tx_bit_r  <= 3'h0;
                    if (tx_go) begin
                        tx_sh_r <= data_wr_data_i;
                        if (mode_i == UAS_MODE_SYNC) begin
                            tx_st_r <= UAS_TX_SYNC;
                        end else begin
                            tx_st_r   <= UAS_TX_START;
                            tx_line_r <= 1'b0;
                        end
                    end
                end
                UAS_TX_START: begin
                    if (tx_bit_end) begin
                        tx_st_r   <= UAS_TX_DATA;
                        tx_line_r <= tx_sh_r[0];
                    end
                end
                UAS_TX_DATA: begin
                    if (tx_bit_end) begin
                        tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
                        tx_bit_r <= tx_bit_r + 3'h1;
                        if (tx_bit_r != UAS_LAST_BIT) begin
                            tx_line_r <= tx_sh_r[1];
                        end else if (nine_bit) begin
                            tx_st_r   <= UAS_TX_NINTH;
                            tx_line_r <= tx_ninth_bit_i;
                        end else begin
                            tx_st_r   <= UAS_TX_STOP;
                            tx_line_r <= 1'b1;
                        end
                    end
                end
                UAS_TX_NINTH: begin
                    if (tx_bit_end) begin
                        tx_st_r   <= UAS_TX_STOP;
                        tx_line_r <= 1'b1;
                    end
                end
                UAS_TX_STOP: begin
                    if (tx_bit_end) begin
                        tx_st_r <= UAS_TX_IDLE;
                    end
                end
                UAS_TX_SYNC: begin
                    if (sync_end) begin
                        tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
                        tx_bit_r <= tx_bit_r + 3'h1;
                        if (tx_bit_r == UAS_LAST_BIT) begin
                            tx_st_r <= UAS_TX_IDLE;
                        end
                    end
                end
                default: tx_st_r <= UAS_TX_IDLE;
            endcase
        end
    end

    assign tx_done_set = ((tx_st_r == UAS_TX_SYNC) && sync_end &&
                          (tx_bit_r == UAS_LAST_BIT)) ||
                         (tx_bit_end && ((tx_st_r == UAS_TX_NINTH) ||
                          ((tx_st_r == UAS_TX_DATA) && !nine_bit &&
                           (tx_bit_r == UAS_LAST_BIT))));

    // Pin drive
    assign serial_out_o   = (mode_i == UAS_MODE_SYNC) ?
                            !(sync_act && (sdiv_r < UAS_SYNC_HALF)) : tx_line_r;
    assign serial_in_o    = 1'b0;
    assign serial_in_oe_o = (tx_st_r == UAS_TX_SYNC) && !tx_sh_r[0];

    // Receiver
    logic [7:0] rx_sh_r;
    logic [2:0] rx_bit_r;
    logic [3:0] rx_os_r;
    logic       rx_nin_r;
    logic       rx_mid;
    logic       stop_seen;
    logic       ninth_val;
    logic       accept;
    logic       pushed;
    logic       rx_done_r;
    uas_stream_if #(.W(UAS_DATA_BITS)) rx_if ();

    assign rx_mid    = os_tick[1] && (rx_os_r == UAS_OS_LAST);
    assign stop_seen = (rx_st_r == UAS_RX_STOP) && rx_mid;
    assign ninth_val = nine_bit ? rx_nin_r : in_sync_r;
    assign accept    = (stop_seen && !rx_done_r &&
                        (!multiproc_enable_bit_i || ninth_val)) ||
                       (rx_st_r == UAS_RX_SYNC_DONE);
    assign rx_if.valid = accept;
    assign rx_if.data  = rx_sh_r;
    assign pushed      = accept && rx_if.ready;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_st_r  <= UAS_RX_IDLE;
            rx_sh_r  <= 8'h00;
            rx_bit_r <= 3'h0;
            rx_os_r  <= 4'h0;
            rx_nin_r <= 1'b0;
        end else begin
            if (os_tick[1]) begin
                rx_os_r <= rx_os_r + 4'h1;
            end
            case (rx_st_r)
                UAS_RX_IDLE: begin
                    rx_os_r  <= 4'h0;
                    rx_bit_r <= 3'h0;
                    if (rx_enable_bit_i && mode_i == UAS_MODE_SYNC) begin
                        if (!rx_done_r && tx_st_r == UAS_TX_IDLE && !data_wr_i) begin
                            rx_st_r <= UAS_RX_SYNC;
                        end
                    end else if (rx_enable_bit_i && in_prev_r && !in_sync_r) begin
                        rx_st_r <= UAS_RX_START;
                    end
                end
                UAS_RX_START: begin
                    if (os_tick[1] && rx_os_r == UAS_OS_MID) begin
                        rx_os_r <= 4'h0;
                        rx_st_r <= in_sync_r ? UAS_RX_IDLE : UAS_RX_DATA;
                    end
                end
                UAS_RX_DATA: begin
                    if (rx_mid) begin
                        rx_sh_r  <= {in_sync_r, rx_sh_r[7:1]};
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == UAS_LAST_BIT) begin
                            rx_st_r <= nine_bit ? UAS_RX_NINTH : UAS_RX_STOP;
                        end
                    end
                end
                UAS_RX_NINTH: begin
                    if (rx_mid) begin
                        rx_nin_r <= in_sync_r;
                        rx_st_r  <= UAS_RX_STOP;
                    end
                end
                UAS_RX_STOP: begin
                    if (rx_mid) begin
                        rx_st_r <= UAS_RX_IDLE;
                    end
                end
                UAS_RX_SYNC: begin
                    if (sync_rise) begin
                        rx_sh_r <= {in_sync_r, rx_sh_r[7:1]};
                    end
                    if (sync_end) begin
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == UAS_LAST_BIT) begin
                            rx_st_r <= UAS_RX_SYNC_DONE;
                        end
                    end
                end
                UAS_RX_SYNC_DONE: rx_st_r <= UAS_RX_IDLE;
                default:          rx_st_r <= UAS_RX_IDLE;
            endcase
        end
    end

    uas_hold_buf #(.W(UAS_DATA_BITS)) u_hold (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .in_if       (rx_if),
        .out_valid_o (rx_data_valid_o),
        .out_ready_i (data_rd_i),
        .out_data_o  (serial_data_buffer_o)
    );

    // Flags: set beats clear
    logic tx_done_r;
    logic nin_flag_r;
    logic col_r;
    logic ovr_r;
    logic fe_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_done_r <= 1'b0;
            rx_done_r <= 1'b0;
        end else begin
            tx_done_r <= tx_done_set || (tx_done_r && !tx_done_clr_i);
            rx_done_r <= pushed || (rx_done_r && !rx_done_clr_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            nin_flag_r <= 1'b0;
        end else if (pushed && mode_i != UAS_MODE_SYNC) begin
            nin_flag_r <= ninth_val;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            col_r <= 1'b0;
            ovr_r <= 1'b0;
            fe_r  <= 1'b0;
        end else begin
            col_r <= (data_wr_i && wr_busy) || (col_r && !tx_collision_clr_i);
            ovr_r <= (accept && (rx_data_valid_o || !rx_if.ready)) ||
                     (ovr_r && !rx_overrun_clr_i);
            fe_r  <= (stop_seen && !in_sync_r) || (fe_r && !frame_error_clr_i);
        end
    end

    assign tx_done_flag_o      = tx_done_r;
    assign rx_done_flag_o      = rx_done_r;
    assign rx_ninth_bit_o      = nin_flag_r;
    assign tx_collision_flag_o = col_r;
    assign rx_overrun_flag_o   = ovr_r;
    assign frame_error_flag_o  = fe_r;
    assign irq_o               = int_enable_i && (tx_done_r || rx_done_r);
endmodule
`default_nettype wire

// ---- uas_sva.sv ----
// Port assertions.
// Assumes one clock domain.
`timescale 1ns/10ps
`default_nettype none
module uas_sva (
    input wire logic       clk_i,
    input wire logic       srst_i,
    input wire logic [1:0] mode_i,
    input wire logic       int_enable_i,
    input wire logic       data_wr_i,
    input wire logic       data_rd_i,
    input wire logic       tx_done_clr_i,
    input wire logic       rx_done_clr_i,
    input wire logic       tx_done_flag_o,
    input wire logic       rx_done_flag_o,
    input wire logic       tx_collision_flag_o,
    input wire logic       rx_overrun_flag_o,
    input wire logic       rx_data_valid_o,
    input wire logic       tx_busy_o,
    input wire logic       irq_o,
    input wire logic       serial_in_oe_o,
    input wire logic       serial_out_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    AST_IRQ: assert property (irq_o == (int_enable_i && (tx_done_flag_o || rx_done_flag_o)))
        else $error("irq wrong");
    AST_TX_KEEP: assert property (tx_done_flag_o && !tx_done_clr_i |=> tx_done_flag_o)
        else $error("tx done lost");
    AST_RX_KEEP: assert property (rx_done_flag_o && !rx_done_clr_i |=> rx_done_flag_o)
        else $error("rx done lost");
    AST_COLL: assert property (data_wr_i && tx_busy_o |=> tx_collision_flag_o)
        else $error("no collision");
    AST_START: assert property ($rose(tx_busy_o) && mode_i != 2'h0 |-> !serial_out_o)
        else $error("no start bit");
    AST_IDLE: assert property (!tx_busy_o && mode_i != 2'h0 |-> serial_out_o)
        else $error("idle line low");
    AST_OE: assert property (mode_i != 2'h0 |-> !serial_in_oe_o)
        else $error("pin driven");
    AST_RX_DV: assert property ($rose(rx_done_flag_o) |-> rx_data_valid_o)
        else $error("byte not held");
    AST_OVR: assert property ($rose(rx_done_flag_o) && $past(rx_data_valid_o)
        && !$past(data_rd_i) |-> ##[0:1] rx_overrun_flag_o)
        else $error("no overrun");
    AST_SYNC_DIV: assert property ($fell(serial_out_o) && mode_i == 2'h0
        |-> !serial_out_o [*6] ##1 serial_out_o)
        else $error("shift clock");
endmodule
bind uas_serial_port uas_sva u_sva (.*);
`default_nettype wire

// ---- uas_peer.sv ----
// Serial peer: async link and mode 0 shift register.
// Assumes BIT system clocks per async bit.
`timescale 1ns/10ps
`default_nettype none
module uas_peer #(parameter int BIT = 32) (
    input  wire logic  clk_i,
    input  wire logic  sync_i,
    input  wire logic  pin_i,
    input  wire logic  oe_i,
    output logic       line_o,
    output logic [7:0] got_o,
    output logic       got_stb_o
);
    logic [7:0] d;
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_o = f[i];
            repeat (BIT) @(posedge clk_i);
            #1;
        end
        line_o = 1'b1;
    endtask
    initial begin
        line_o = 1'b1;
        got_stb_o = 1'b0;
        got_o = 8'h00;
        forever begin
            @(negedge pin_i);
            for (int i = 0; i < 8; i++) begin
                if (sync_i) begin
                    if (i > 0) @(negedge pin_i);
                    @(posedge pin_i);
                    d[i] = !oe_i;
                end else begin
                    repeat (i > 0 ? BIT : BIT + BIT / 2) @(posedge clk_i);
                    d[i] = pin_i;
                end
            end
            got_o = d;
            #1 got_stb_o = 1'b1;
            @(posedge clk_i);
            #1 got_stb_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- uas_serial_port_tb.sv ----
// Bench: async traffic, flags, mode 0 transmit.
// Assumes peer and checker compiled first.
`timescale 1ns/10ps
`default_nettype none
module uas_serial_port_tb;
    import uas_pkg::*;
    logic        clk_i, srst_i, rx_enable_bit_i, multiproc_enable_bit_i, double_speed_bit_i;
    logic        tx_clock_sel_hi_i, tx_clock_sel_lo_i, rx_clock_sel_hi_i, rx_clock_sel_lo_i;
    logic        int_enable_i, tx_ninth_bit_i, timer_one_input_clock_i, data_wr_i, data_rd_i;
    logic        tx_done_clr_i, rx_done_clr_i, tx_collision_clr_i, rx_overrun_clr_i;
    logic        frame_error_clr_i, rx_data_valid_o, tx_done_flag_o, rx_done_flag_o;
    logic        rx_ninth_bit_o, tx_collision_flag_o, rx_overrun_flag_o, frame_error_flag_o;
    logic        tx_busy_o, irq_o, serial_in_i, serial_in_o, serial_in_oe_o, serial_out_o;
    logic        got_stb, line;
    logic [1:0]  mode_i;
    logic [2:0]  wide_timer_input_clock_i;
    logic [7:0]  timer_one_reload_i, data_wr_data_i, serial_data_buffer_o, got, b;
    logic [47:0] wide_timer_reload_i;
    logic [31:0] seed = 32'hA475D1FB;
    logic [7:0]  exp_tx[$], exp_rx[$];
    int          err_count = 0, n_checks = 0, cyc = 0;
    uas_serial_port uut (.*);
    uas_peer peer (.clk_i, .sync_i(mode_i == 2'h0), .pin_i(serial_out_o),
                   .oe_i(serial_in_oe_o), .line_o(line), .got_o(got), .got_stb_o(got_stb));
    assign serial_in_i = line & !serial_in_oe_o;
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask
    task automatic tally_and_finish;
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (got_stb === 1'b1) chk(got, exp_tx.size() ? exp_tx.pop_front() : 8'hXX);
        if (data_rd_i === 1'b1 && rx_data_valid_o === 1'b1)
            chk(serial_data_buffer_o, exp_rx.size() ? exp_rx.pop_front() : 8'hXX);
        cyc++;
        if (cyc > 8000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        {mode_i, rx_enable_bit_i, multiproc_enable_bit_i, double_speed_bit_i, int_enable_i} = '0;
        {tx_clock_sel_hi_i, tx_clock_sel_lo_i, rx_clock_sel_hi_i, rx_clock_sel_lo_i} = '0;
        {tx_ninth_bit_i, data_wr_i, data_rd_i, data_wr_data_i, tx_done_clr_i} = '0;
        {rx_done_clr_i, tx_collision_clr_i, rx_overrun_clr_i, frame_error_clr_i} = '0;
        {timer_one_input_clock_i, wide_timer_input_clock_i} = 4'hF;
        wide_timer_reload_i = 48'hFFFEFFFEFFFE;
        timer_one_reload_i = 8'hFE;
        srst_i = 1'b1;
        tick(10);
        srst_i = 1'b0;
        chk({serial_out_o, tx_done_flag_o, rx_done_flag_o, tx_collision_flag_o,
             rx_overrun_flag_o, frame_error_flag_o, tx_busy_o, rx_data_valid_o}, 8'h80);
        mode_i = UAS_MODE_ASYNC8;
        rx_enable_bit_i = 1'b1;
        for (int i = 0; i < 5; i++) begin
            {tx_clock_sel_hi_i, tx_clock_sel_lo_i} = 2'(i % 4);
            {rx_clock_sel_hi_i, rx_clock_sel_lo_i} = 2'(3 - i % 4);
            double_speed_bit_i = (i != 4);
            timer_one_reload_i = (i == 4) ? 8'hFF : 8'hFE;
            seed = lfsr(seed);
            int_enable_i = seed[16];
            b = seed[7:0];
            exp_tx.push_back(b);
            exp_rx.push_back(seed[15:8]);
            data_wr_data_i = b;
            fork
                peer.send(seed[15:8], 1'b1);
                begin
                    pulse(data_wr_i);
                    tick(4);
                    data_wr_data_i = ~b;
                    pulse(data_wr_i);
                    chk(8'(tx_collision_flag_o), 8'h01);
                    pulse(tx_collision_clr_i);
                end
            join
            tick(40);
            chk({4'h0, tx_done_flag_o, rx_done_flag_o, tx_busy_o, rx_ninth_bit_o}, 8'h0D);
            pulse(tx_done_clr_i);
            pulse(rx_done_clr_i);
            chk({6'h00, tx_done_flag_o, rx_done_flag_o}, 8'h00);
            pulse(data_rd_i);
        end
        exp_rx.push_back(8'h5A);
        exp_rx.push_back(8'hA5);
        peer.send(8'h5A, 1'b1);
        tick(8);
        pulse(rx_done_clr_i);
        peer.send(8'hA5, 1'b1);
        tick(8);
        chk({5'h00, rx_done_flag_o, rx_overrun_flag_o, rx_data_valid_o}, 8'h07);
        pulse(rx_done_clr_i);
        multiproc_enable_bit_i = 1'b1;
        peer.send(8'h3C, 1'b0);
        tick(8);
        chk({4'h0, rx_done_flag_o, frame_error_flag_o, rx_ninth_bit_o, rx_overrun_flag_o},
            8'h07);
        data_rd_i = 1'b1;
        tick(2);
        data_rd_i = 1'b0;
        chk(8'(rx_data_valid_o), 8'h00);
        {rx_enable_bit_i, multiproc_enable_bit_i} = '0;
        mode_i = UAS_MODE_SYNC;
        tick(2);
        exp_tx.push_back(8'hC3);
        data_wr_data_i = 8'hC3;
        pulse(data_wr_i);
        tick(110);
        chk({7'h00, tx_done_flag_o}, 8'h01);
        chk(8'(exp_tx.size() + exp_rx.size()), 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
